/* File: gtc_cfg.svh */
// gated timer capture: register offsets, fields, reset values, timing
// assumes inclusion by the top module only
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

// ----------------------------------------
// register word offsets (consecutive addresses)
// ----------------------------------------
`define GTC_OFS_MAIN_CTRL 4'h0
`define GTC_OFS_GATE_CTRL 4'h1
`define GTC_OFS_CAP_CTRL 4'h2
`define GTC_OFS_CAP_FLAG 4'h3
`define GTC_OFS_COUNTER 4'h4
`define GTC_OFS_CAPTURE 4'h5
`define GTC_OFS_TIMERS 4'h6
`define GTC_OFS_WDT_CTRL 4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define GTC_MC_ON 0
`define GTC_MC_EXT 1
`define GTC_MC_SLEEP 2
`define GTC_GC_EN 0
`define GTC_GC_POL 1
`define GTC_GC_SS_LO 2
`define GTC_GC_SS_HI 3
`define GTC_WD_RATE_HI 2
`define GTC_WD_PSA 3
`define GTC_WD_CLR 4

// ----------------------------------------
// capture mode codes
// ----------------------------------------
`define GTC_CM_FALL 4'h4
`define GTC_CM_RISE 4'h5
`define GTC_CM_RISE4 4'h6
`define GTC_CM_RISE16 4'h7

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define GTC_PERIOD_RST 8'hFF
`define GTC_WDT_BASE_US 18
`define GTC_CLK_MHZ 100
`define GTC_WDT_BASE_CYC (`GTC_WDT_BASE_US * `GTC_CLK_MHZ)
`define GTC_PS_DIV 4

`endif

/* File: gtc_pkg.sv */
// gated timer capture: shared types
// assumes no include file; gtc_cfg.svh is not used here
package gtc_pkg;
  typedef enum logic [1:0] {
    GTC_SRC_PIN,
    GTC_SRC_T8,
    GTC_SRC_PERIOD,
    GTC_SRC_WDT
  } gtc_src_e;
  typedef logic [15:0] gtc_cnt_t;
endpackage

/* File: gtc_top.sv */
// gated timer capture: 16-bit gated counter with input capture unit
// assumes an Avalon-MM master on clk, pins from outside the clock domain
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "gtc_cfg.svh"

module gtc_top
  import gtc_pkg::*;
#(
  parameter int WDT_BASE_CYC = `GTC_WDT_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic gate_input_pin,
  input wire logic capture_pin,
  input wire logic ext_clk_pin,
  // status
  output logic capture_flag,
  output logic watchdog_osc_on
);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic ack_q;
  logic wr_stb;
  logic rd_stb;
  logic [3:0] idx;
  assign idx = avs_address[3:0];
  // one wait cycle; a write lands on the edge that sees waitrequest low
  assign wr_stb = avs_write && ack_q;
  assign rd_stb = avs_read && !ack_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [2:0] main_ctrl_q;
  logic [3:0] gate_control_reg_q;
  logic [3:0] capture_control_reg_q;
  logic [7:0] period_timer_limit_q;
  logic [3:0] wdt_ctrl_q;
  logic wdt_restart;
  logic main_counter_on;
  logic ext_mode;
  logic sleep_q;
  logic gate_count_enable;
  logic gate_polarity;
  gtc_src_e gate_source_select;
  logic [3:0] capture_mode_field;
  assign main_counter_on = main_ctrl_q[`GTC_MC_ON];
  assign ext_mode = main_ctrl_q[`GTC_MC_EXT];
  assign sleep_q = main_ctrl_q[`GTC_MC_SLEEP];
  assign gate_count_enable = gate_control_reg_q[`GTC_GC_EN];
  assign gate_polarity = gate_control_reg_q[`GTC_GC_POL];
  assign gate_source_select = gtc_src_e'(gate_control_reg_q[`GTC_GC_SS_HI:`GTC_GC_SS_LO]);
  assign capture_mode_field = capture_control_reg_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_ctrl_q <= 3'h0;
      gate_control_reg_q <= 4'h0;
      capture_control_reg_q <= 4'h0;
      period_timer_limit_q <= `GTC_PERIOD_RST;
      wdt_ctrl_q <= 4'h0;
    end else if (wr_stb) begin
      unique case (idx)
        `GTC_OFS_MAIN_CTRL: main_ctrl_q <= avs_writedata[2:0];
        `GTC_OFS_GATE_CTRL: gate_control_reg_q <= avs_writedata[3:0];
        // prescaler count is not touched here, only by mode leaving capture
        `GTC_OFS_CAP_CTRL: capture_control_reg_q <= avs_writedata[3:0];
        `GTC_OFS_TIMERS: period_timer_limit_q <= avs_writedata[15:8];
        `GTC_OFS_WDT_CTRL: wdt_ctrl_q <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // sleep entry, wake and clear instruction each restart the interval
  assign wdt_restart = wr_stb && ((idx == `GTC_OFS_WDT_CTRL && avs_writedata[`GTC_WD_CLR])
    || (idx == `GTC_OFS_MAIN_CTRL && avs_writedata[`GTC_MC_SLEEP] != sleep_q));

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_raw;
  assign pin_raw = {ext_clk_pin, capture_pin, gate_input_pin};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic ext_rise;
  logic cap_rise;
  logic cap_fall;
  assign ext_rise = pin_s2_q[2] && !pin_s3_q[2];
  assign cap_rise = pin_s2_q[1] && !pin_s3_q[1];
  assign cap_fall = !pin_s2_q[1] && pin_s3_q[1];

  // ----------------------------------------
  // clock source: fosc/4 tick or external edge
  // ----------------------------------------
  logic [1:0] div_q;
  logic tick;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // internal tick stops in sleep, external edges keep running
  assign tick = ext_mode ? ext_rise : (div_q == 2'h3 && !sleep_q);

  // ----------------------------------------
  // gate source timers
  // ----------------------------------------
  logic [7:0] overflow_timer_count_q;
  logic [7:0] period_timer_count_q;
  logic t8_pulse_q;
  logic period_pulse_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow_timer_count_q <= 8'h00;
      t8_pulse_q <= 1'b0;
    end else begin
      t8_pulse_q <= 1'b0;
      if (tick) begin
        overflow_timer_count_q <= overflow_timer_count_q + 8'h01;
        t8_pulse_q <= (overflow_timer_count_q == 8'hFF);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_timer_count_q <= 8'h00;
      period_pulse_q <= 1'b0;
    end else begin
      period_pulse_q <= 1'b0;
      if (tick) begin
        if (period_timer_count_q == period_timer_limit_q) begin
          period_timer_count_q <= 8'h00;
          period_pulse_q <= 1'b1;
        end else begin
          period_timer_count_q <= period_timer_count_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // watchdog interval for gate use
  // ----------------------------------------
  logic wdt_gate_on;
  logic [31:0] wdt_base_q;
  logic [7:0] wdt_ps_q;
  logic wdt_pulse_q;
  logic wdt_step;
  logic [7:0] wdt_limit;
  assign wdt_gate_on = gate_count_enable && gate_source_select == GTC_SRC_WDT;
  assign wdt_step = (wdt_base_q == 32'(WDT_BASE_CYC - 1));
  // rate and assignment still set the interval; changing them mid-run can glitch
  assign wdt_limit = wdt_ctrl_q[`GTC_WD_PSA] ? (8'h01 << wdt_ctrl_q[`GTC_WD_RATE_HI:0]) - 8'h01 : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst || !wdt_gate_on || wdt_restart) begin
      wdt_base_q <= 32'h0;
      wdt_ps_q <= 8'h00;
      wdt_pulse_q <= 1'b0;
    end else begin
      wdt_pulse_q <= 1'b0;
      wdt_base_q <= wdt_step ? 32'h0 : wdt_base_q + 32'h1;
      if (wdt_step) begin
        if (wdt_ps_q >= wdt_limit) begin
          wdt_ps_q <= 8'h00;
          wdt_pulse_q <= 1'b1; // no reset or wake is raised from here
        end else begin
          wdt_ps_q <= wdt_ps_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_osc_on <= 1'b0;
    end else begin
      watchdog_osc_on <= wdt_gate_on; // independent of main_counter_on
    end
  end

  // ----------------------------------------
  // gate and main counter
  // ----------------------------------------
  logic gate_raw;
  logic gate_active;

  always_comb begin
    unique case (gate_source_select)
      GTC_SRC_PIN: gate_raw = pin_s2_q[0];
      GTC_SRC_T8: gate_raw = t8_pulse_q;
      GTC_SRC_PERIOD: gate_raw = period_pulse_q;
      GTC_SRC_WDT: gate_raw = wdt_pulse_q;
    endcase
  end

  assign gate_active = !gate_count_enable || (gate_raw == gate_polarity);

  gtc_cnt_t main_counter_value_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_counter_value_q <= 16'h0000;
    end else if (wr_stb && idx == `GTC_OFS_COUNTER) begin
      main_counter_value_q <= avs_writedata[15:0];
    end else if (main_counter_on && tick && gate_active) begin
      main_counter_value_q <= main_counter_value_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // capture unit
  // ----------------------------------------
  logic cap_mode;
  logic [3:0] cap_ps_q;
  logic cap_event;
  logic ps_edge;
  assign cap_mode = capture_mode_field >= `GTC_CM_FALL && capture_mode_field <= `GTC_CM_RISE16;
  // a pin wired back as output still feeds the edge detector
  assign ps_edge = (capture_mode_field == `GTC_CM_FALL) ? cap_fall : cap_rise;

  always_comb begin
    unique case (capture_mode_field)
      `GTC_CM_FALL: cap_event = cap_fall;
      `GTC_CM_RISE: cap_event = cap_rise;
      `GTC_CM_RISE4: cap_event = cap_rise && cap_ps_q[1:0] == 2'h3;
      `GTC_CM_RISE16: cap_event = cap_rise && cap_ps_q == 4'hF;
      default: cap_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !cap_mode) begin
      cap_ps_q <= 4'h0;
    end else if (ps_edge) begin
      cap_ps_q <= cap_ps_q + 4'h1;
    end
  end

  gtc_cnt_t capture_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture_q <= 16'h0000;
    end else if (cap_event) begin
      capture_q <= main_counter_value_q; // overwrites unread value
    end
  end

  // set beats a same-cycle clear; mode changes may set it falsely
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture_flag <= 1'b0;
    end else if (cap_event) begin
      capture_flag <= 1'b1;
    end else if (wr_stb && idx == `GTC_OFS_CAP_FLAG && avs_writedata[0]) begin
      capture_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_stb) begin
      unique case (idx)
        `GTC_OFS_MAIN_CTRL: avs_readdata <= {29'h0, main_ctrl_q};
        `GTC_OFS_GATE_CTRL: avs_readdata <= {28'h0, gate_control_reg_q};
        `GTC_OFS_CAP_CTRL: avs_readdata <= {28'h0, capture_control_reg_q};
        `GTC_OFS_CAP_FLAG: avs_readdata <= {31'h0, capture_flag};
        `GTC_OFS_COUNTER: avs_readdata <= {16'h0, main_counter_value_q};
        `GTC_OFS_CAPTURE: avs_readdata <= {16'h0, capture_q};
        `GTC_OFS_TIMERS: avs_readdata <= {8'h0, period_timer_count_q, period_timer_limit_q,
          overflow_timer_count_q};
        `GTC_OFS_WDT_CTRL: avs_readdata <= {27'h0, watchdog_osc_on, wdt_ctrl_q};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule

/* File: gtc_top_props.sv */
// checker: bus answer, capture flag and watchdog enable relations
// assumes gtc_top ports only, one clock, sync active-high reset
`timescale 1ns/100ps
module gtc_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and status
  input wire logic capture_pin,
  input wire logic capture_flag,
  input wire logic watchdog_osc_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wd_cfg;
  assign wd_cfg = avs_write && avs_address == 4'h1;
  AST_ANSWER: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered");
  AST_LOW_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_IDLE: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  AST_UNMAPPED: assert property (avs_read && avs_address[3] && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_FLAG_HOLD: assert property (capture_flag && !(avs_write && avs_address == 4'h3) |=> capture_flag)
    else $error("flag cleared by itself");
  // pin held at least 6 clks, so one change sits in this window
  AST_FLAG_CAUSE: assert property ($rose(capture_flag) |-> $past(capture_pin, 1) != $past(capture_pin, 6))
    else $error("flag without pin edge");
  AST_WDT_ON: assert property (wd_cfg && avs_writedata[0] && avs_writedata[3:2] == 2'b11
    |-> ##[1:3] watchdog_osc_on)
    else $error("watchdog not started");
  AST_WDT_OFF: assert property (wd_cfg && !avs_writedata[0] |-> ##[1:3] !watchdog_osc_on)
    else $error("watchdog not stopped");
  AST_OSC_CAUSE: assert property ($rose(watchdog_osc_on) |-> $past(wd_cfg) || $past(wd_cfg, 2))
    else $error("watchdog on without config");
endmodule

bind gtc_top gtc_top_props i_gtc_top_props (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .capture_pin(capture_pin), .capture_flag(capture_flag),
  .watchdog_osc_on(watchdog_osc_on));

/* File: gtc_pins.sv */
// partner: external source driving gate, capture and count clock pins
// assumes the caller sits on clk; pins change right after rising edges
`timescale 1ns/100ps
module gtc_pins (
  // clock
  input wire logic clk,
  // pins
  output logic gate_input_pin,
  output logic capture_pin,
  output logic ext_clk_pin
);
  initial begin
    gate_input_pin = 1'b0;
    capture_pin = 1'b0;
    ext_clk_pin = 1'b0;
  end
  // 6 clk hold so the 2-flop sync sees each edge once
  task automatic set_cap(input logic v);
    @(posedge clk);
    capture_pin <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic set_gate(input logic v);
    @(posedge clk);
    gate_input_pin <= v;
    repeat (6) @(posedge clk);
  endtask
  // count clock stands low between bursts
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

/* File: gtc_top_test.sv */
// testbench for gtc_top: bus tasks, pin partner, scenario tasks
// assumes gtc_pins partner and the bound checker
`timescale 1ns/100ps
module gtc_top_test;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, capture_flag, watchdog_osc_on;
  logic gate_input_pin, capture_pin, ext_clk_pin;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  int bad_count = 0;
  int compares = 0;
  gtc_top #(.WDT_BASE_CYC(20)) i_gtc_top (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gate_input_pin(gate_input_pin), .capture_pin(capture_pin),
    .ext_clk_pin(ext_clk_pin), .capture_flag(capture_flag), .watchdog_osc_on(watchdog_osc_on));
  gtc_pins i_gtc_pins (.clk(clk), .gate_input_pin(gate_input_pin), .capture_pin(capture_pin),
    .ext_clk_pin(ext_clk_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic t_reset;
    rdchk(4'h1, 32'h0);
    bus(1'b0, 4'h6, 32'h0);
    chk({24'h0, rd_q[15:8]}, 32'hFF);
    bus(1'b1, 4'h9, 32'hFFFFFFFF);
    rdchk(4'h9, 32'h0);
    chk({31'h0, capture_flag}, 32'h0);
  endtask
  task automatic t_gate;
    bus(1'b1, 4'h0, 32'h3);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 4'h1, 32'(s * 4 + 2));
      bus(1'b1, 4'h4, 32'h0);
      i_gtc_pins.ticks(2);
      rdchk(4'h4, 32'h2);
      rdchk(4'h1, 32'(s * 4 + 2));
    end
    for (int k = 0; k < 4; k++) begin
      i_gtc_pins.set_gate(k[0]);
      bus(1'b1, 4'h1, 32'(k[1] * 2 + 1));
      bus(1'b1, 4'h4, 32'h0);
      i_gtc_pins.ticks(3);
      rdchk(4'h4, (k[0] == k[1]) ? 32'h3 : 32'h0);
    end
  endtask
  task automatic t_wdt;
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h1, 32'hD);
    repeat (3) @(posedge clk);
    chk({31'h0, watchdog_osc_on}, 32'h1);
    bus(1'b1, 4'h7, 32'h10);
    rdchk(4'h7, 32'h10);
    bus(1'b1, 4'h1, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, watchdog_osc_on}, 32'h0);
  endtask
  task automatic t_cap;
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h2, 32'h5);
    bus(1'b1, 4'h3, 32'h1);
    i_gtc_pins.ticks(7);
    i_gtc_pins.set_cap(1'b1);
    chk({31'h0, capture_flag}, 32'h1);
    i_gtc_pins.ticks(2);
    i_gtc_pins.set_cap(1'b0);
    rdchk(4'h5, 32'h7);
    i_gtc_pins.set_cap(1'b1);
    rdchk(4'h5, 32'h9);
    rdchk(4'h3, 32'h1);
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h2, 32'h4);
    bus(1'b1, 4'h3, 32'h1);
    rdchk(4'h3, 32'h0);
    i_gtc_pins.ticks(1);
    i_gtc_pins.set_cap(1'b0);
    rdchk(4'h5, 32'hA);
  endtask
  // two pulses first, then off and on again must restart the count
  task automatic t_pre(input logic [31:0] m, input int n);
    bus(1'b1, 4'h2, m);
    repeat (2) begin
      i_gtc_pins.set_cap(1'b1);
      i_gtc_pins.set_cap(1'b0);
    end
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h2, m);
    bus(1'b1, 4'h3, 32'h1);
    repeat (n - 1) begin
      i_gtc_pins.set_cap(1'b1);
      i_gtc_pins.set_cap(1'b0);
    end
    chk({31'h0, capture_flag}, 32'h0);
    i_gtc_pins.set_cap(1'b1);
    chk({31'h0, capture_flag}, 32'h1);
    i_gtc_pins.set_cap(1'b0);
  endtask
  // mid-run reset, then the period timer must wrap to zero after its match
  task automatic t_mid;
    logic [7:0] p;
    logic [7:0] o;
    bus(1'b1, 4'h2, 32'h6);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, 4'h0, 32'h3);
    rdchk(4'h2, 32'h0);
    bus(1'b1, 4'h6, 32'h300);
    bus(1'b0, 4'h6, 32'h0);
    p = rd_q[23:16];
    o = rd_q[7:0] + 8'h05;
    repeat (5) p = (p == 8'h03) ? 8'h00 : p + 8'h01;
    i_gtc_pins.ticks(5);
    rdchk(4'h6, {8'h0, p, 8'h03, o});
    bus(1'b1, 4'h2, 32'h6);
    repeat (3) begin
      i_gtc_pins.set_cap(1'b1);
      i_gtc_pins.set_cap(1'b0);
    end
    chk({31'h0, capture_flag}, 32'h0);
    i_gtc_pins.set_cap(1'b1);
    chk({31'h0, capture_flag}, 32'h1);
    i_gtc_pins.set_cap(1'b0);
  endtask
  task automatic t_sleep;
    bus(1'b1, 4'h0, 32'h5);
    bus(1'b1, 4'h4, 32'h64);
    repeat (40) @(posedge clk);
    rdchk(4'h4, 32'h64);
    bus(1'b1, 4'h0, 32'h1);
    repeat (40) @(posedge clk);
    bus(1'b0, 4'h4, 32'h0);
    chk({31'h0, rd_q > 32'h64}, 32'h1);
    bus(1'b1, 4'h0, 32'h7);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h2, 32'h5);
    bus(1'b1, 4'h3, 32'h1);
    i_gtc_pins.ticks(4);
    i_gtc_pins.set_cap(1'b1);
    rdchk(4'h5, 32'h4);
  endtask
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_gate();
    t_wdt();
    t_cap();
    t_pre(32'h6, 4);
    t_pre(32'h7, 16);
    t_mid();
    t_sleep();
    results();
  end
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
